/* common/ssb_pkg.sv */
/*
 * Package for the supply supervisor: register offsets, field positions,
 * reset values, timing counts and the shared types.
 * Assumes a 32-bit APB register bus and one 40 MHz system clock.
 */
package ssb_pkg;

   // Register byte offsets
   localparam logic [11:0] SSB_CTRL_OFS    = 12'h000;
   localparam logic [11:0] SSB_STATUS_OFS  = 12'h004;
   localparam logic [11:0] SSB_CLEAR_OFS   = 12'h008;
   localparam logic [11:0] SSB_RAIL_OFS    = 12'h00C;

   // Control field positions
   localparam int SSB_CTRL_IO_BOE  = 0;
   localparam int SSB_CTRL_CORE_BOE = 1;
   localparam int SSB_CTRL_ANA_BOE = 2;
   localparam int SSB_CTRL_ANA_PD  = 3;

   // Status / rail bit positions, shared by status, clear and enable
   localparam int SSB_RAIL_IO    = 0;
   localparam int SSB_RAIL_CORE  = 1;
   localparam int SSB_RAIL_ANA   = 2;
   localparam int SSB_NUM_RAILS  = 3;

   // Rail register fields
   localparam int SSB_RAIL_STRAP_BIT  = 3;
   localparam int SSB_RAIL_RESET_BIT  = 4;
   localparam int SSB_RAIL_CORE_REG_BIT = 5;

   // Control reset value: enables clear, analog power-down set
   localparam logic [3:0] SSB_CTRL_RESET = 4'h8;

   localparam logic [15:0] SSB_RESET_VECTOR = 16'h8000;

   // Reset stretch after the core rail recovers
   localparam int SSB_CLK_HZ         = 40_000_000;
   localparam int SSB_RST_STRETCH_NS = 1000;
   localparam int SSB_RST_STRETCH_CYC =
      (SSB_RST_STRETCH_NS * (SSB_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SSB_CNT_W = 8;

   typedef enum logic [1:0] {
      SSB_ST_HOLD,
      SSB_ST_STRETCH,
      SSB_ST_RUN
   } ssb_state_t;

   typedef struct packed {
      logic [SSB_NUM_RAILS-1:0] low;   // Rail below brownout threshold
      logic core_below_por;            // Core rail under reset threshold
      logic core_above_1v;             // Core rail above 1V
   } ssb_rails_t;

   typedef struct packed {
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ssb_req_t;

endpackage

/* core/ssb_sync.sv */
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs may change at any time relative to clk_i.
 */
`timescale 1ns/100ps
module ssb_sync
   import ssb_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_i,    // System clock
   input  wire logic         rst_n_i,  // Async reset, active low
   input  wire logic [W-1:0] d_i,      // Asynchronous levels
   output logic      [W-1:0] q_o       // Synchronised levels
);

   logic [W-1:0] meta_q;

   // First stage is read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule

/* core/ssb_irq.sv */
/*
 * Sticky brownout flags with per-rail enable and one level interrupt.
 * Assumes event inputs are synchronous to clk_i.
 */
`timescale 1ns/100ps
module ssb_irq
   import ssb_pkg::*;
(
   input  wire logic                     clk_i,    // System clock
   input  wire logic                     rst_n_i,  // Async reset, active low
   input  wire logic [SSB_NUM_RAILS-1:0] event_i,  // Brownout onset pulses
   input  wire logic [SSB_NUM_RAILS-1:0] clear_i,  // Clear strobes
   input  wire logic [SSB_NUM_RAILS-1:0] enable_i, // Interrupt enables
   output logic      [SSB_NUM_RAILS-1:0] flag_o,   // Sticky flags
   output logic                          irq_o     // Interrupt level
);

   for (genvar i = 0; i < SSB_NUM_RAILS; i++) begin : g_flag
      // Set wins over a clear in the same cycle
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            flag_o[i] <= 1'b0;
         end else if (event_i[i]) begin
            flag_o[i] <= 1'b1;
         end else if (clear_i[i]) begin
            flag_o[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((flag_o | event_i) & ~(clear_i & ~event_i) & enable_i);
      end
   end

endmodule

/* core/ssb_supervisor.sv */
/*
 * Supply supervisor: brownout monitoring of the I/O, core and analog
 * rails, core reset sequencing, reset pin drive, regulator gating and
 * an APB register file.
 * Assumes rail comparator levels and the reset pin are asynchronous
 * and that the strap is stable while reset is asserted.
 */
`timescale 1ns/100ps
module ssb_supervisor
   import ssb_pkg::*;
(
   input  wire logic        clk_i,             // System clock, 40 MHz
   input  wire logic        rst_n_i,           // Async reset, active low
   input  wire logic        psel,              // APB select
   input  wire logic        penable,           // APB enable
   input  wire logic        pwrite,            // APB direction
   input  wire logic [11:0] paddr,             // APB byte address
   input  wire logic [31:0] pwdata,            // APB write data
   output logic      [31:0] prdata,            // APB read data
   output logic             pready,            // APB ready
   output logic             pslverr,           // APB error
   input  wire logic        io_rail_low_i,     // I/O rail below brownout
   input  wire logic        core_rail_low_i,   // Core rail below brownout
   input  wire logic        ana_rail_low_i,    // Analog rail below brownout
   input  wire logic        core_below_por_i,  // Core rail below reset threshold
   input  wire logic        core_above_1v_i,   // Core rail above 1V
   input  wire logic        core_regulator_strap_i, // Strap, high = external core
   input  wire logic        reset_pin_i,       // Reset pin level
   output logic             reset_pin_o,       // Reset pin drive value
   output logic             reset_pin_oe_o,    // Reset pin drive enable
   output logic             cpu_reset_n_o,     // Processor reset, active low
   output logic [15:0]      cpu_reset_vector_o, // Fetch address after reset
   output logic             ana_reg_en_o,      // Analog regulator enable
   output logic             core_reg_en_o,     // Core regulator enable
   output logic             irq_o              // Brownout interrupt level
);

   ////////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      ssb_state_t                state;
      logic [SSB_CNT_W-1:0]      cnt;
      logic [3:0]                ctrl;
      logic [SSB_NUM_RAILS-1:0]  low_prev;
      logic                      strap;
      logic                      strap_taken;
      logic                      reset_out;
      logic [31:0]               rdata;
      logic                      ready;
      logic                      slverr;
      logic                      core_reg_en;
      logic                      ana_reg_en;
   } ssb_regs_t;

   ssb_regs_t s_q;
   ssb_regs_t s_d;

   ssb_rails_t              rail_raw;
   ssb_rails_t              rail_s;
   logic                    pin_s;
   logic                    strap_s;
   logic [SSB_NUM_RAILS-1:0] bo_event;
   logic [SSB_NUM_RAILS-1:0] bo_clear;
   logic [SSB_NUM_RAILS-1:0] bo_enable;
   logic [SSB_NUM_RAILS-1:0] bo_flag;
   logic                    irq_int;
   ssb_req_t                req;
   logic                    acc_en;
   logic                    hold_rst;
   logic                    sync_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for all pin-level inputs

   assign rail_raw.low[SSB_RAIL_IO]   = io_rail_low_i;
   assign rail_raw.low[SSB_RAIL_CORE] = core_rail_low_i;
   assign rail_raw.low[SSB_RAIL_ANA]  = ana_rail_low_i;
   assign rail_raw.core_below_por     = core_below_por_i;
   assign rail_raw.core_above_1v      = core_above_1v_i;

   ssb_sync #(
      .W ($bits(ssb_rails_t) + 3)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({rail_raw, reset_pin_i, core_regulator_strap_i, 1'b1}),
      .q_o     ({rail_s, pin_s, strap_s, sync_ok})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Brownout flags and interrupt

   // Monitors fire on the falling edge of each rail
   assign bo_event  = rail_s.low & ~s_q.low_prev;
   assign bo_enable = {s_q.ctrl[SSB_CTRL_ANA_BOE],
                       s_q.ctrl[SSB_CTRL_CORE_BOE],
                       s_q.ctrl[SSB_CTRL_IO_BOE]};

   assign req.write = pwrite;
   assign req.addr  = paddr;
   assign req.wdata = pwdata;
   assign acc_en    = psel && penable && !s_q.ready;
   assign bo_clear  = (acc_en && req.write && req.addr == SSB_CLEAR_OFS) ?
                      req.wdata[SSB_NUM_RAILS-1:0] : '0;

   ssb_irq u_irq (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .event_i  (bo_event),
      .clear_i  (bo_clear),
      .enable_i (bo_enable),
      .flag_o   (bo_flag),
      .irq_o    (irq_int)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Core is dead below 1V; reset is asserted on core_below_por whether or not the rail is above 1V
   assign hold_rst = rail_s.core_below_por && rail_s.core_above_1v;

   always_comb begin
      s_d          = s_q;
      s_d.low_prev = rail_s.low;
      s_d.ready    = 1'b0;
      s_d.slverr   = 1'b0;

      // Strap caught once, only after the synchroniser has filled
      if (!s_q.strap_taken && sync_ok) begin
         s_d.strap       = strap_s;
         s_d.strap_taken = 1'b1;
      end
      s_d.core_reg_en = s_q.strap_taken && !s_q.strap;

      unique case (s_q.state)
         SSB_ST_HOLD: begin
            s_d.reset_out = 1'b1;
            if (sync_ok && !hold_rst && !rail_s.core_below_por) begin
               s_d.state = SSB_ST_STRETCH;
               s_d.cnt   = '0;
            end
         end
         SSB_ST_STRETCH: begin
            // Short stretch filters comparator chatter at threshold
            if (hold_rst || rail_s.core_below_por) begin
               s_d.state = SSB_ST_HOLD;
            end else if (s_q.cnt == SSB_CNT_W'(SSB_RST_STRETCH_CYC - 1)) begin
               s_d.state     = SSB_ST_RUN;
               s_d.reset_out = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
         end
         SSB_ST_RUN: begin
            if (rail_s.core_below_por) begin
               s_d.state     = SSB_ST_HOLD;
               s_d.reset_out = 1'b1;
            end
         end
      endcase

      // Any core reset returns control to its safe value
      if (s_d.reset_out) begin
         s_d.ctrl = SSB_CTRL_RESET;
      end

      // APB access phase, one wait state
      if (acc_en) begin
         s_d.ready = 1'b1;
         if (req.write) begin
            unique case (req.addr)
               SSB_CTRL_OFS: begin
                  if (!s_d.reset_out) begin
                     s_d.ctrl = req.wdata[3:0];
                  end
               end
               SSB_CLEAR_OFS: begin
                  s_d.slverr = 1'b0;
               end
               default: begin
                  s_d.slverr = 1'b1;
               end
            endcase
            s_d.rdata = '0;
         end else begin
            unique case (req.addr)
               SSB_CTRL_OFS:   s_d.rdata = {28'h0000000, s_q.ctrl};
               SSB_STATUS_OFS: s_d.rdata = {29'h00000000, bo_flag};
               SSB_CLEAR_OFS:  s_d.rdata = '0;
               SSB_RAIL_OFS: begin
                  s_d.rdata = '0;
                  s_d.rdata[SSB_NUM_RAILS-1:0]   = rail_s.low;
                  s_d.rdata[SSB_RAIL_STRAP_BIT]  = s_q.strap;
                  s_d.rdata[SSB_RAIL_RESET_BIT]  = s_q.reset_out;
                  s_d.rdata[SSB_RAIL_CORE_REG_BIT] = s_q.core_reg_en;
               end
               default: begin
                  s_d.rdata  = '0;
                  s_d.slverr = 1'b1;
               end
            endcase
         end
      end

      // Analog regulator off unless software cleared power-down
      s_d.ana_reg_en = !s_d.ctrl[SSB_CTRL_ANA_PD] && !s_d.reset_out;
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q             <= '0;
         s_q.state       <= SSB_ST_HOLD;
         s_q.ctrl        <= SSB_CTRL_RESET;
         s_q.reset_out   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops except reset_pin_o, which is tied low

   assign prdata         = s_q.rdata;
   assign pready         = s_q.ready;
   assign pslverr        = s_q.slverr;
   assign reset_pin_o    = 1'b0;
   assign reset_pin_oe_o = s_q.reset_out;
   assign ana_reg_en_o   = s_q.ana_reg_en;
   assign core_reg_en_o  = s_q.core_reg_en;
   assign irq_o          = irq_int;

   // External pin low also holds the processor; no fetch while held
   logic cpu_rst_n_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_rst_n_q <= 1'b0;
      end else begin
         cpu_rst_n_q <= !s_d.reset_out && pin_s;
      end
   end
   assign cpu_reset_n_o = cpu_rst_n_q;

   logic [15:0] vec_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vec_q <= SSB_RESET_VECTOR;
      end else begin
         vec_q <= SSB_RESET_VECTOR;
      end
   end
   assign cpu_reset_vector_o = vec_q;

endmodule

/* test/ssb_supervisor_sva.sv */
/* Port checker for the supply supervisor.
   Assumes it is bound to ssb_supervisor and that there is one clock domain. */
`timescale 1ns/100ps
module ssb_supervisor_sva
   import ssb_pkg::*;
(
   input wire logic        clk_i, // Clock
   input wire logic        rst_n_i, // Reset
   input wire logic        psel, // APB select
   input wire logic        penable, // APB enable
   input wire logic        pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB data
   input wire logic        pready, // APB ready
   input wire logic        pslverr, // APB error
   input wire logic        core_below_por_i, // Core under threshold
   input wire logic        core_above_1v_i, // Core above 1V
   input wire logic        reset_pin_o, // Pin value
   input wire logic        reset_pin_oe_o, // Pin enable
   input wire logic        cpu_reset_n_o, // CPU reset
   input wire logic [15:0] cpu_reset_vector_o, // Fetch address
   input wire logic        ana_reg_en_o, // Analog regulator
   input wire logic        irq_o // Interrupt
);
   logic       wr_ctrl;
   logic [2:0] en_q;
   logic [7:0] up_q;

   assign wr_ctrl = psel && penable && pready && pwrite && !pslverr && paddr == SSB_CTRL_OFS;

   // Enable mirror; control falls back to its reset value while reset is driven
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_q <= 3'h0;
         up_q <= 8'h00;
      end else begin
         if (reset_pin_oe_o) begin
            en_q <= 3'h0;
         end else if (wr_ctrl) begin
            en_q <= pwdata[2:0];
         end
         if (core_below_por_i) begin
            up_q <= 8'h00;
         end else if (up_q != 8'hFF) begin
            up_q <= up_q + 8'h01;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_IRQ_MASK: assert property ((en_q == 3'h0)[*3] |-> !irq_o)
      else $error("interrupt with all enables clear");
   AST_ANA_OFF: assert property (reset_pin_oe_o[*3] |-> !ana_reg_en_o)
      else $error("analog regulator on during reset");
   AST_ANA_ON: assert property (wr_ctrl && !pwdata[SSB_CTRL_ANA_PD] &&
      !reset_pin_oe_o && !$past(reset_pin_oe_o) |-> ##[1:2] ana_reg_en_o)
      else $error("analog regulator not switched on");
   AST_POR_HOLD: assert property ((core_below_por_i && core_above_1v_i)[*4]
      |-> ##[0:2] reset_pin_oe_o)
      else $error("reset not driven with core below threshold");
   AST_STRETCH: assert property ($fell(reset_pin_oe_o) |-> up_q >= 8'h28)
      else $error("reset released too early");
   AST_CPU_HELD: assert property (reset_pin_oe_o[*2] |-> !cpu_reset_n_o)
      else $error("processor running while reset is driven");
   AST_CPU_RELEASE: assert property ($rose(cpu_reset_n_o) |->
      !$past(reset_pin_oe_o) && cpu_reset_vector_o == SSB_RESET_VECTOR)
      else $error("processor released badly");
   AST_PIN_DRIVE: assert property (reset_pin_oe_o |-> !reset_pin_o)
      else $error("reset pin driven high");
endmodule

bind ssb_supervisor ssb_supervisor_sva u_ssb_supervisor_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .core_below_por_i(core_below_por_i), .core_above_1v_i(core_above_1v_i),
   .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .cpu_reset_n_o(cpu_reset_n_o),
   .cpu_reset_vector_o(cpu_reset_vector_o), .ana_reg_en_o(ana_reg_en_o), .irq_o(irq_o));

/* test/ssb_supply_model.sv */
/* Behavioural supply monitors, strap and reset pin with its pull-up.
   Assumes the bench calls the tasks; the device only ever drives the pin low. */
`timescale 1ns/100ps
module ssb_supply_model
   import ssb_pkg::*;
(
   input  wire logic clk_i, // Clock
   input  wire logic reset_pin_o, // Device pin value
   input  wire logic reset_pin_oe_o, // Device pin enable
   output logic      io_low_o, // I/O rail low
   output logic      core_low_o, // Core rail low
   output logic      ana_low_o, // Analog rail low
   output logic      below_por_o, // Core under threshold
   output logic      above_1v_o, // Core above 1V
   output logic      strap_o, // Core regulator strap
   output logic      pin_o // Resolved pin level
);
   logic ext_low_q;

   initial begin
      {io_low_o, core_low_o, ana_low_o, above_1v_o, strap_o, ext_low_q} = 6'h00;
      below_por_o = 1'h1;
   end

   // Pull-up wins unless a party pulls low
   assign pin_o = !((reset_pin_oe_o && !reset_pin_o) || ext_low_q);

   task automatic set_rail(input int r, input logic v);
      @(posedge clk_i);
      case (r)
         SSB_RAIL_IO:   io_low_o <= v;
         SSB_RAIL_CORE: core_low_o <= v;
         default:       ana_low_o <= v;
      endcase
   endtask

   // A core above its reset threshold is always above 1V
   task automatic set_core(input logic below, input logic above);
      @(posedge clk_i);
      below_por_o <= below;
      above_1v_o <= above || !below;
   endtask

   task automatic set_ext(input logic v);
      @(posedge clk_i);
      ext_low_q <= v;
   endtask

   task automatic set_strap(input logic v);
      @(posedge clk_i);
      strap_o <= v;
   endtask
endmodule

/* test/tb_top.sv */
/* Self-checking bench: APB master, supply model and one task per scenario.
   Assumes the checker binds itself to the design. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top
   import ssb_pkg::*;
;
   logic        clk_i = 1'h0;
   logic        rst_n_i = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic        pready, pslverr, ev, io_l, core_l, ana_l, below, above, strap, pin;
   logic        pin_oe, pin_v, cpu_n, ana_en, core_en, irq;
   logic [15:0] vec;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles = 0;

   always #12.5 clk_i = !clk_i;

   ssb_supervisor u_ssb_supervisor (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .io_rail_low_i(io_l), .core_rail_low_i(core_l), .ana_rail_low_i(ana_l),
      .core_below_por_i(below), .core_above_1v_i(above), .core_regulator_strap_i(strap),
      .reset_pin_i(pin), .reset_pin_o(pin_v), .reset_pin_oe_o(pin_oe), .cpu_reset_n_o(cpu_n),
      .cpu_reset_vector_o(vec), .ana_reg_en_o(ana_en), .core_reg_en_o(core_en), .irq_o(irq));
   ssb_supply_model u_ssb_supply_model (
      .clk_i(clk_i), .reset_pin_o(pin_v), .reset_pin_oe_o(pin_oe), .io_low_o(io_l),
      .core_low_o(core_l), .ana_low_o(ana_l), .below_por_o(below), .above_1v_o(above),
      .strap_o(strap), .pin_o(pin));

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'h1 && n < 64);
      rv = prdata;
      ev = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n == 64) num_errors++;
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      `CHK(nm, x, rv)
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wait_cpu(input logic v, output int n);
      n = 0;
      while (cpu_n !== v && n < 300) begin
         tick(1);
         n++;
      end
   endtask

   task automatic t_power_up(input logic s);
      int n;
      @(posedge clk_i);
      rst_n_i <= 1'h0;
      u_ssb_supply_model.set_core(1'h1, 1'h0);
      u_ssb_supply_model.set_strap(s);
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'h1;
      tick(8);
      `CHK("pin", 1'h0, pin)
      `CHK("cpu_n", 1'h0, cpu_n)
      `CHK("core_en", !s, core_en)
      apb(1'h1, SSB_CTRL_OFS, 32'h7);
      rd("ctrl_lock", SSB_CTRL_OFS, 32'h8);
      `CHK("ana_en", 1'h0, ana_en)
      u_ssb_supply_model.set_core(1'h1, 1'h1);
      tick(20);
      `CHK("hold", 1'h0, cpu_n)
      u_ssb_supply_model.set_core(1'h0, 1'h1);
      wait_cpu(1'h1, n);
      `CHK("stretch", 1'h1, n >= 40 && n <= 56)
      `CHK("vec", SSB_RESET_VECTOR, vec)
      rd("rail", SSB_RAIL_OFS, {26'h0, !s, 1'h0, s, 3'h0});
   endtask

   task automatic t_ana_on();
      apb(1'h1, SSB_CTRL_OFS, 32'h0);
      tick(3);
      `CHK("ana_on", 1'h1, ana_en)
   endtask

   task automatic t_brownout();
      int o;
      for (int r = 0; r < SSB_NUM_RAILS; r++) begin
         o = (r + 1) % SSB_NUM_RAILS;
         apb(1'h1, SSB_CTRL_OFS, 32'(1 << r));
         u_ssb_supply_model.set_rail(o, 1'h1);
         tick(6);
         `CHK("masked", 1'h0, irq)
         u_ssb_supply_model.set_rail(o, 1'h0);
         u_ssb_supply_model.set_rail(r, 1'h1);
         tick(6);
         u_ssb_supply_model.set_rail(r, 1'h0);
         tick(6);
         `CHK("irq", 1'h1, irq)
         rd("status", SSB_STATUS_OFS, 32'(1 << r) | 32'(1 << o));
         apb(1'h1, SSB_CTRL_OFS, 32'h0);
         tick(3);
         `CHK("irq_off", 1'h0, irq)
         apb(1'h1, SSB_CLEAR_OFS, 32'(1 << r));
         rd("cleared", SSB_STATUS_OFS, 32'(1 << o));
         apb(1'h1, SSB_CLEAR_OFS, 32'h7);
      end
      apb(1'h0, 12'h010, 32'h0);
      `CHK("unmapped", 1'h1, ev)
   endtask

   task automatic t_ext_reset();
      int n;
      u_ssb_supply_model.set_ext(1'h1);
      wait_cpu(1'h0, n);
      `CHK("ext_oe", 1'h0, pin_oe)
      u_ssb_supply_model.set_ext(1'h0);
      wait_cpu(1'h1, n);
      `CHK("ext_rel", 1'h1, n < 8)
   endtask

   task automatic t_core_drop();
      int n;
      u_ssb_supply_model.set_core(1'h1, 1'h1);
      wait_cpu(1'h0, n);
      `CHK("drop", 1'h1, n < 8)
      tick(4);
      `CHK("drop_ana", 1'h0, ana_en)
      rd("drop_ctrl", SSB_CTRL_OFS, 32'h8);
      u_ssb_supply_model.set_core(1'h0, 1'h1);
      wait_cpu(1'h1, n);
      `CHK("recover", 1'h1, n >= 40 && n < 300)
   endtask

   initial begin
      t_power_up(1'h0);
      t_ana_on();
      t_brownout();
      t_ext_reset();
      t_core_drop();
      t_power_up(1'h1);
      wrap_up();
   end
endmodule
